// ==== core/gpt_defs.svh ====
`ifndef GPT_DEFS_SVH
`define GPT_DEFS_SVH

// Bus map: block select in address bits 7:6, register in bits 5:0
`define GPT_ADDR_W        8
`define GPT_ALT_SEL_ADDR  8'hc0
`define GPT_OFF_CFG       6'h00
`define GPT_OFF_MODE_A    6'h04
`define GPT_OFF_MODE_B    6'h08
`define GPT_OFF_CTL       6'h0c
`define GPT_OFF_RIS       6'h10
`define GPT_OFF_ICR       6'h14
`define GPT_OFF_LOAD_A    6'h18
`define GPT_OFF_LOAD_B    6'h1c
`define GPT_OFF_MATCH_A   6'h20
`define GPT_OFF_MATCH_B   6'h24
`define GPT_OFF_PRE_A     6'h28
`define GPT_OFF_PRE_B     6'h2c
`define GPT_OFF_PMATCH_A  6'h30
`define GPT_OFF_PMATCH_B  6'h34
`define GPT_OFF_COUNT_A   6'h38
`define GPT_OFF_COUNT_B   6'h3c

// Configuration classes
`define GPT_CFG_32        3'h0
`define GPT_CFG_RTC       3'h1
`define GPT_CFG_16        3'h4

// Half timer mode field
`define GPT_TMR_ONESHOT   2'h1
`define GPT_TMR_PERIODIC  2'h2
`define GPT_TMR_CAPTURE   2'h3

// Control register bit positions
`define GPT_CTL_EN_A      0
`define GPT_CTL_STALL_A   1
`define GPT_CTL_EN_B      8
`define GPT_CTL_STALL_B   9

// Raw status bit positions, half B at +stride
`define GPT_RIS_TO        0
`define GPT_RIS_MATCH     1
`define GPT_RIS_CAP       2
`define GPT_RIS_STRIDE    3
`define GPT_RIS_RTC       6

// Reset and load values
`define GPT_CNT_RESET     16'hffff
`define GPT_PRE_RESET     8'h00
`define GPT_RTC_START     32'h0000_0001
`define GPT_RTC_DIV       15'h7fff

`endif

// ==== core/gpt_pkg.sv ====
package gpt_pkg;

    typedef struct packed {
        logic       inv;
        logic       ams;
        logic       cmr;
        logic [1:0] tmr;
    } gpt_mode_t;

    typedef struct packed {
        logic      [2:0]       cfg;
        gpt_mode_t [1:0]       mode;
        logic      [1:0]       en;
        logic      [1:0]       stall;
        logic      [6:0]       ris;
        logic      [1:0][15:0] load;
        logic      [1:0][15:0] match;
        logic      [1:0][7:0]  pre;
        logic      [1:0][7:0]  pmatch;
        logic      [1:0][15:0] cnt;
        logic      [1:0][7:0]  pc;
        logic      [1:0][15:0] cap;
        logic      [14:0]      div;
    } gpt_blk_t;

    typedef struct packed {
        gpt_blk_t [2:0] blk;
        logic     [5:0] alt;
        logic     [5:0] sync1;
        logic     [5:0] sync2;
        logic     [5:0] prev;
        logic     [5:0] pwm;
        logic     [5:0] pin_out;
        logic     [5:0] pin_oe;
        logic     [31:0] rd_data;
    } gpt_state_t;

endpackage : gpt_pkg

// ==== core/gpt_top.sv ====
// How it works
// - Three timer blocks, each separately configured
// - Two 16-bit halves, or one 32-bit timer/clock
// - Counters, match, prescale match, load per half
// - 32-bit one-shot, periodic and real-time clock
// - 16-bit timing with prescaler, timer modes only
// - Capture modes: edge count and edge time
// - Simple PWM with optional output inversion
// - Optional stall while debug halt asserted, except clock and edge count
// - Config register plus per-half mode registers
// - 32-bit mode single timer; 16-bit any mix
// - Reset leaves block inactive, controls cleared
// - Reset counters and load registers to all ones
// - Reset prescale registers to zero
// - Pins stay general-purpose until alternate select set
// - Config 0 32-bit, 1 clock, 4 split
// - 32-bit load writes both, count reads both
// - At zero reload, flag time-out, one-shot stops
// - Even pin 32.768 kHz divided to 1 Hz
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "gpt_defs.svh"

module gpt_top
    import gpt_pkg::*;
(
    input  wire logic                    mclk,
    input  wire logic                    rst_n,
    input  wire logic [`GPT_ADDR_W-1:0]  addr,
    input  wire logic [31:0]             wr_data,
    input  wire logic                    wr_en,
    input  wire logic                    rd_en,
    output logic      [31:0]             rd_data,
    input  wire logic                    debug_halt,
    input  wire logic [5:0]              pin_in,
    input  wire logic [5:0]              gpio_out,
    input  wire logic [5:0]              gpio_oe,
    output logic      [5:0]              pin_out,
    output logic      [5:0]              pin_oe
);

    gpt_state_t s;
    gpt_state_t next_s;

    assign rd_data = s.rd_data;
    assign pin_out = s.pin_out;
    assign pin_oe  = s.pin_oe;

    always_comb
    begin
        logic [5:0]  rise;
        logic [6:0]  set_bits;
        logic [6:0]  clr_bits;
        logic [31:0] c32;
        logic [31:0] m32;
        logic [15:0] nc;
        logic        run;
        logic        wsel;
        logic        rsel;
        logic [5:0]  off;
        int          p;
        next_s = s;
        rise = '0;
        set_bits = '0;
        clr_bits = '0;
        c32 = '0;
        m32 = '0;
        nc = '0;
        run = 1'b0;
        wsel = 1'b0;
        rsel = 1'b0;
        off = addr[5:0];
        p = 0;
        next_s.sync1 = pin_in;
        next_s.sync2 = s.sync1;
        next_s.prev  = s.sync2;
        // Pins are always synchronised, but edges only count once handed to the timer
        rise = s.sync2 & ~s.prev & s.alt;
        next_s.rd_data = '0;
        if (wr_en && addr == `GPT_ALT_SEL_ADDR)
        begin
            next_s.alt = wr_data[5:0];
        end
        if (rd_en && addr == `GPT_ALT_SEL_ADDR)
        begin
            next_s.rd_data = {26'h0, s.alt};
        end
        for (int b = 0; b < 3; b++)
        begin
            set_bits = '0;
            clr_bits = '0;
            c32 = {s.blk[b].cnt[1], s.blk[b].cnt[0]};
            m32 = {s.blk[b].match[1], s.blk[b].match[0]};
            if (s.blk[b].cfg == `GPT_CFG_32)
            begin
                // Halves joined; half B mode is ignored here
                run = s.blk[b].en[0] && !(s.blk[b].stall[0] && debug_halt);
                if (run)
                begin
                    if (c32 == 32'h0)
                    begin
                        c32 = {s.blk[b].load[1], s.blk[b].load[0]};
                        set_bits[`GPT_RIS_TO] = 1'b1;
                        if (s.blk[b].mode[0].tmr == `GPT_TMR_ONESHOT)
                        begin
                            next_s.blk[b].en[0] = 1'b0;
                        end
                    end
                    else
                    begin
                        c32 = c32 - 32'h1;
                    end
                end
                {next_s.blk[b].cnt[1], next_s.blk[b].cnt[0]} = c32;
            end
            else if (s.blk[b].cfg == `GPT_CFG_RTC)
            begin
                // Clock mode ignores stall so wall time stays true
                if (s.blk[b].en[0] && rise[2*b])
                begin
                    if (s.blk[b].div == `GPT_RTC_DIV)
                    begin
                        next_s.blk[b].div = '0;
                        if (c32 == m32)
                        begin
                            c32 = 32'h0;
                            set_bits[`GPT_RIS_RTC] = 1'b1;
                        end
                        else
                        begin
                            c32 = c32 + 32'h1;
                        end
                    end
                    else
                    begin
                        next_s.blk[b].div = s.blk[b].div + 15'h1;
                    end
                end
                {next_s.blk[b].cnt[1], next_s.blk[b].cnt[0]} = c32;
            end
            else if (s.blk[b].cfg == `GPT_CFG_16)
            begin
                for (int h = 0; h < 2; h++)
                begin
                    p = 2 * b + h;
                    run = s.blk[b].en[h] && !(s.blk[b].stall[h] && debug_halt);
                    if (s.blk[b].mode[h].tmr == `GPT_TMR_CAPTURE)
                    begin
                        if (s.blk[b].mode[h].ams)
                        begin
                            // PWM: no prescaler, period from load
                            if (run)
                            begin
                                next_s.blk[b].cnt[h] = (s.blk[b].cnt[h] == 16'h0) ? s.blk[b].load[h]
                                                                                  : s.blk[b].cnt[h] - 16'h1;
                            end
                            next_s.pwm[p] = (s.blk[b].cnt[h] > s.blk[b].match[h])
                                            ^ s.blk[b].mode[h].inv;
                        end
                        else if (!s.blk[b].mode[h].cmr)
                        begin
                            // Edge count stops itself on reaching the match
                            if (s.blk[b].en[h] && rise[p])
                            begin
                                nc = s.blk[b].cnt[h] - 16'h1;
                                next_s.blk[b].cnt[h] = nc;
                                if (nc == s.blk[b].match[h])
                                begin
                                    set_bits[h*`GPT_RIS_STRIDE+`GPT_RIS_MATCH] = 1'b1;
                                    next_s.blk[b].en[h] = 1'b0;
                                end
                            end
                        end
                        else
                        begin
                            if (run)
                            begin
                                next_s.blk[b].cnt[h] = (s.blk[b].cnt[h] == 16'h0) ? s.blk[b].load[h]
                                                                                  : s.blk[b].cnt[h] - 16'h1;
                            end
                            if (s.blk[b].en[h] && rise[p])
                            begin
                                next_s.blk[b].cap[h] = s.blk[b].cnt[h];
                                set_bits[h*`GPT_RIS_STRIDE+`GPT_RIS_CAP] = 1'b1;
                            end
                        end
                    end
                    else if (s.blk[b].mode[h].tmr == `GPT_TMR_ONESHOT ||
                             s.blk[b].mode[h].tmr == `GPT_TMR_PERIODIC)
                    begin
                        if (run)
                        begin
                            if (s.blk[b].cnt[h] == s.blk[b].match[h] &&
                                s.blk[b].pc[h] == s.blk[b].pmatch[h])
                            begin
                                set_bits[h*`GPT_RIS_STRIDE+`GPT_RIS_MATCH] = 1'b1;
                            end
                            if (s.blk[b].pc[h] != 8'h0)
                            begin
                                next_s.blk[b].pc[h] = s.blk[b].pc[h] - 8'h1;
                            end
                            else if (s.blk[b].cnt[h] == 16'h0)
                            begin
                                next_s.blk[b].cnt[h] = s.blk[b].load[h];
                                next_s.blk[b].pc[h] = s.blk[b].pre[h];
                                set_bits[h*`GPT_RIS_STRIDE+`GPT_RIS_TO] = 1'b1;
                                if (s.blk[b].mode[h].tmr == `GPT_TMR_ONESHOT)
                                begin
                                    next_s.blk[b].en[h] = 1'b0;
                                end
                            end
                            else
                            begin
                                next_s.blk[b].cnt[h] = s.blk[b].cnt[h] - 16'h1;
                                next_s.blk[b].pc[h] = s.blk[b].pre[h];
                            end
                        end
                    end
                end
            end
            // Software writes come last so they override counting
            wsel = wr_en && addr[7:6] == 2'(b);
            rsel = rd_en && addr[7:6] == 2'(b);
            if (wsel)
            begin
                if (off == `GPT_OFF_CFG)
                begin
                    next_s.blk[b].cfg = wr_data[2:0];
                    if (wr_data[2:0] == `GPT_CFG_RTC)
                    begin
                        {next_s.blk[b].cnt[1], next_s.blk[b].cnt[0]} = `GPT_RTC_START;
                        next_s.blk[b].div = '0;
                    end
                end
                else if (off == `GPT_OFF_MODE_A)
                begin
                    next_s.blk[b].mode[0] = wr_data[4:0];
                end
                else if (off == `GPT_OFF_MODE_B)
                begin
                    next_s.blk[b].mode[1] = wr_data[4:0];
                end
                else if (off == `GPT_OFF_CTL)
                begin
                    next_s.blk[b].en[0]    = wr_data[`GPT_CTL_EN_A];
                    next_s.blk[b].stall[0] = wr_data[`GPT_CTL_STALL_A];
                    next_s.blk[b].en[1]    = wr_data[`GPT_CTL_EN_B];
                    next_s.blk[b].stall[1] = wr_data[`GPT_CTL_STALL_B];
                end
                else if (off == `GPT_OFF_ICR)
                begin
                    clr_bits = wr_data[6:0];
                end
                else if (off == `GPT_OFF_LOAD_A)
                begin
                    // A new load takes effect on the next cycle
                    next_s.blk[b].load[0] = wr_data[15:0];
                    next_s.blk[b].cnt[0]  = wr_data[15:0];
                    if (s.blk[b].cfg != `GPT_CFG_16)
                    begin
                        next_s.blk[b].load[1] = wr_data[31:16];
                        next_s.blk[b].cnt[1]  = wr_data[31:16];
                    end
                end
                else if (off == `GPT_OFF_LOAD_B)
                begin
                    next_s.blk[b].load[1] = wr_data[15:0];
                    next_s.blk[b].cnt[1]  = wr_data[15:0];
                end
                else if (off == `GPT_OFF_MATCH_A)
                begin
                    next_s.blk[b].match[0] = wr_data[15:0];
                    if (s.blk[b].cfg != `GPT_CFG_16)
                    begin
                        next_s.blk[b].match[1] = wr_data[31:16];
                    end
                end
                else if (off == `GPT_OFF_MATCH_B)
                begin
                    next_s.blk[b].match[1] = wr_data[15:0];
                end
                else if (off == `GPT_OFF_PRE_A)
                begin
                    next_s.blk[b].pre[0] = wr_data[7:0];
                end
                else if (off == `GPT_OFF_PRE_B)
                begin
                    next_s.blk[b].pre[1] = wr_data[7:0];
                end
                else if (off == `GPT_OFF_PMATCH_A)
                begin
                    next_s.blk[b].pmatch[0] = wr_data[7:0];
                end
                else if (off == `GPT_OFF_PMATCH_B)
                begin
                    next_s.blk[b].pmatch[1] = wr_data[7:0];
                end
            end
            // A new event beats a clear in the same cycle
            next_s.blk[b].ris = (s.blk[b].ris & ~clr_bits) | set_bits;
            if (rsel)
            begin
                if (off == `GPT_OFF_CFG)
                begin
                    next_s.rd_data = {29'h0, s.blk[b].cfg};
                end
                else if (off == `GPT_OFF_MODE_A)
                begin
                    next_s.rd_data = {27'h0, s.blk[b].mode[0]};
                end
                else if (off == `GPT_OFF_MODE_B)
                begin
                    next_s.rd_data = {27'h0, s.blk[b].mode[1]};
                end
                else if (off == `GPT_OFF_CTL)
                begin
                    next_s.rd_data = {22'h0, s.blk[b].stall[1], s.blk[b].en[1], 6'h0,
                                      s.blk[b].stall[0], s.blk[b].en[0]};
                end
                else if (off == `GPT_OFF_RIS)
                begin
                    next_s.rd_data = {25'h0, s.blk[b].ris};
                end
                else if (off == `GPT_OFF_LOAD_A)
                begin
                    next_s.rd_data = (s.blk[b].cfg == `GPT_CFG_16) ? {16'h0, s.blk[b].load[0]}
                                                                   : {s.blk[b].load[1], s.blk[b].load[0]};
                end
                else if (off == `GPT_OFF_LOAD_B)
                begin
                    next_s.rd_data = {16'h0, s.blk[b].load[1]};
                end
                else if (off == `GPT_OFF_MATCH_A)
                begin
                    next_s.rd_data = (s.blk[b].cfg == `GPT_CFG_16) ? {16'h0, s.blk[b].match[0]} : m32;
                end
                else if (off == `GPT_OFF_MATCH_B)
                begin
                    next_s.rd_data = {16'h0, s.blk[b].match[1]};
                end
                else if (off == `GPT_OFF_PRE_A)
                begin
                    next_s.rd_data = {24'h0, s.blk[b].pre[0]};
                end
                else if (off == `GPT_OFF_PRE_B)
                begin
                    next_s.rd_data = {24'h0, s.blk[b].pre[1]};
                end
                else if (off == `GPT_OFF_PMATCH_A)
                begin
                    next_s.rd_data = {24'h0, s.blk[b].pmatch[0]};
                end
                else if (off == `GPT_OFF_PMATCH_B)
                begin
                    next_s.rd_data = {24'h0, s.blk[b].pmatch[1]};
                end
                else if (off == `GPT_OFF_COUNT_A)
                begin
                    if (s.blk[b].cfg != `GPT_CFG_16)
                    begin
                        next_s.rd_data = {s.blk[b].cnt[1], s.blk[b].cnt[0]};
                    end
                    else if (s.blk[b].mode[0].tmr == `GPT_TMR_CAPTURE && s.blk[b].mode[0].cmr &&
                             !s.blk[b].mode[0].ams)
                    begin
                        next_s.rd_data = {16'h0, s.blk[b].cap[0]};
                    end
                    else
                    begin
                        next_s.rd_data = {16'h0, s.blk[b].cnt[0]};
                    end
                end
                else if (off == `GPT_OFF_COUNT_B)
                begin
                    if (s.blk[b].mode[1].tmr == `GPT_TMR_CAPTURE && s.blk[b].mode[1].cmr &&
                        !s.blk[b].mode[1].ams)
                    begin
                        next_s.rd_data = {16'h0, s.blk[b].cap[1]};
                    end
                    else
                    begin
                        next_s.rd_data = {16'h0, s.blk[b].cnt[1]};
                    end
                end
            end
            for (int h = 0; h < 2; h++)
            begin
                p = 2 * b + h;
                // Timer drives only in PWM with the pin handed over
                if (s.alt[p])
                begin
                    next_s.pin_out[p] = s.pwm[p];
                    next_s.pin_oe[p]  = s.blk[b].cfg == `GPT_CFG_16 && s.blk[b].en[h] &&
                                        s.blk[b].mode[h].tmr == `GPT_TMR_CAPTURE && s.blk[b].mode[h].ams;
                end
                else
                begin
                    next_s.pin_out[p] = gpio_out[p];
                    next_s.pin_oe[p]  = gpio_oe[p];
                end
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            s <= '0;
            for (int b = 0; b < 3; b++)
            begin
                s.blk[b].cnt  <= {`GPT_CNT_RESET, `GPT_CNT_RESET};
                s.blk[b].load <= {`GPT_CNT_RESET, `GPT_CNT_RESET};
                s.blk[b].pre  <= {`GPT_PRE_RESET, `GPT_PRE_RESET};
            end
        end
        else
        begin
            s <= next_s;
        end
    end

endmodule : gpt_top

// ==== tb/gpt_top_sva.sv ====
`timescale 1ns/100ps
`include "gpt_defs.svh"

module gpt_top_sva
    import gpt_pkg::*;
(
    input wire logic                   mclk,
    input wire logic                   rst_n,
    input wire logic [`GPT_ADDR_W-1:0] addr,
    input wire logic [31:0]            wr_data,
    input wire logic                   wr_en,
    input wire logic                   rd_en,
    input wire logic [31:0]            rd_data,
    input wire logic                   debug_halt,
    input wire logic [5:0]             pin_in,
    input wire logic [5:0]             gpio_out,
    input wire logic [5:0]             gpio_oe,
    input wire logic [5:0]             pin_out,
    input wire logic [5:0]             pin_oe
);
    logic [5:0] alt;
    logic [5:0] next_alt;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Shadow of alternate select
    always_comb next_alt = (wr_en && addr == `GPT_ALT_SEL_ADDR) ? wr_data[5:0] : alt;
    always_ff @(posedge mclk) alt <= rst_n ? next_alt : 6'h00;

    a_read_idle_zero: assert property (!$past(rd_en) |-> rd_data == 32'h0)
        else $error("rd_data not zero outside a read");
    a_alt_read_back: assert property (rd_en && addr == `GPT_ALT_SEL_ADDR |=> rd_data == {26'h0, $past(alt)})
        else $error("alternate select read back wrong");
    a_unmapped_read_zero: assert property (rd_en && addr[7:6] == 2'h3 && addr != `GPT_ALT_SEL_ADDR |=> rd_data == 32'h0)
        else $error("unmapped read not zero");
    a_gpio_out_pass: assert property ($past(rst_n) |-> ((pin_out ^ $past(gpio_out)) & ~$past(alt)) == 6'h0)
        else $error("pin_out not from gpio");
    a_gpio_oe_pass: assert property ($past(rst_n) |-> ((pin_oe ^ $past(gpio_oe)) & ~$past(alt)) == 6'h0)
        else $error("pin_oe not from gpio");
    a_status_upper_zero: assert property (rd_en && addr[7:6] != 2'h3 && addr[5:0] == `GPT_OFF_RIS |=> rd_data[31:7] == 25'h0)
        else $error("status upper bits set");
    a_mode_upper_zero: assert property (rd_en && addr[7:6] != 2'h3 && addr[5:0] == `GPT_OFF_MODE_B |=> rd_data[31:5] == 27'h0)
        else $error("mode upper bits set");
    a_prescale_upper_zero: assert property (rd_en && addr[7:6] != 2'h3 && addr[5:0] == `GPT_OFF_PRE_B |=> rd_data[31:8] == 24'h0)
        else $error("prescale upper bits set");

    c_alt_read: cover property (rd_en && addr == `GPT_ALT_SEL_ADDR);
    c_timer_drive: cover property (|(pin_oe & alt));
    c_halt_read: cover property (debug_halt && rd_en);
endmodule : gpt_top_sva

bind gpt_top gpt_top_sva gpt_top_sva_inst (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .debug_halt(debug_halt), .pin_in(pin_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .pin_out(pin_out), .pin_oe(pin_oe));

// ==== tb/gpt_pin_src.sv ====
`timescale 1ns/100ps

module gpt_pin_src
(
    input  wire logic       mclk,
    input  wire logic [5:0] fire,
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe,
    output logic      [5:0] pin_in
);
    logic [5:0] d1 = 6'h00;
    logic [5:0] d2 = 6'h00;
    logic [5:0] src = 6'h00;

    // Three cycles high, beyond the one-cycle minimum for edge detection
    always_ff @(posedge mclk)
    begin
        d1  <= fire;
        d2  <= d1;
        src <= fire | d1 | d2;
    end

    // Timer drive wins where enabled
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & src);
endmodule : gpt_pin_src

// ==== tb/gpt_top_tb.sv ====
`timescale 1ns/100ps

module gpt_top_tb
    import gpt_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic        debug_halt = 1'b0;
    logic [5:0]  fire = 6'h00;
    logic [5:0]  gpio_out = 6'h00;
    logic [5:0]  gpio_oe = 6'h00;
    logic [31:0] rd_data;
    logic [5:0]  pin_in;
    logic [5:0]  pin_out;
    logic [5:0]  pin_oe;
    int          failures = 0;
    int          checks = 0;

    always #5 mclk = ~mclk;

    gpt_top gpt_top_inst (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .debug_halt(debug_halt), .pin_in(pin_in), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .pin_out(pin_out), .pin_oe(pin_oe));
    gpt_pin_src gpt_pin_src_inst (.mclk(mclk), .fire(fire), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

    task automatic end_of_test();
        if (failures == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Leading edge wait keeps strobe edits in separate time steps
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge mclk);
        wr_en   <= 1'b0;
    endtask : wr

    task automatic rdv(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        @(negedge mclk);
        v = rd_data;
    endtask : rdv

    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rdv(a, v);
        check(what, v, exp);
    endtask : rd

    task automatic poll(input logic [7:0] a, input logic [31:0] mask);
        logic [31:0] v;
        for (int i = 0; i < 200; i++)
        begin
            rdv(a, v);
            if ((v & mask) !== 32'h0)
                return;
        end
        failures++;
        end_of_test();
    endtask : poll

    task automatic pulse(input logic [5:0] p);
        @(posedge mclk);
        fire <= p;
        @(posedge mclk);
        fire <= 6'h00;
        repeat (6) @(posedge mclk);
    endtask : pulse

    task automatic t_reset();
        rd("cfg", 8'h00, 32'h0);
        rd("ctl", 8'h0c, 32'h0);
        rd("load32", 8'h18, 32'hffff_ffff);
        rd("count32", 8'h38, 32'hffff_ffff);
        rd("pre_b", 8'h2c, 32'h0);
        rd("alt", 8'hc0, 32'h0);
        rd("unmapped", 8'hc4, 32'h0);
        check("gpio_pass", {26'h0, pin_out}, 32'h2a);
    endtask : t_reset

    task automatic t_pair32();
        wr(8'h98, 32'h0005_0007);
        rd("pair", 8'hb8, 32'h0005_0007);
        wr(8'h80, 32'h1);
        rd("rtc_start", 8'hb8, 32'h1);
    endtask : t_pair32

    task automatic t_oneshot();
        wr(8'h40, 32'h4);
        wr(8'h44, 32'h1);
        wr(8'h58, 32'h3);
        wr(8'h4c, 32'h1);
        poll(8'h50, 32'h1);
        rd("en_off", 8'h4c, 32'h0);
        rd("reload", 8'h78, 32'h3);
        rd("other_blk", 8'h00, 32'h0);
        wr(8'h54, 32'h3);
        rd("ris_clr", 8'h50, 32'h0);
    endtask : t_oneshot

    task automatic t_stall();
        logic [31:0] v;
        wr(8'h48, 32'h2);
        rd("mode_b", 8'h48, 32'h2);
        wr(8'h5c, 32'h0fff);
        debug_halt <= 1'b1;
        wr(8'h4c, 32'h300);
        rd("frozen", 8'h7c, 32'h0fff);
        @(posedge mclk);
        debug_halt <= 1'b0;
        rdv(8'h7c, v);
        check("resumed", v, 32'h0ffe);
    endtask : t_stall

    task automatic t_edge();
        wr(8'h00, 32'h4);
        wr(8'h04, 32'h3);
        wr(8'h18, 32'ha);
        wr(8'h20, 32'h2);
        wr(8'h0c, 32'h1);
        pulse(6'h01);
        rd("no_alt", 8'h38, 32'ha);
        wr(8'hc0, 32'h1);
        pulse(6'h01);
        pulse(6'h02);
        rd("edge_cnt", 8'h38, 32'h9);
        repeat (8) pulse(6'h01);
        rd("at_match", 8'h38, 32'h2);
        rd("match_flag", 8'h10, 32'h2);
    endtask : t_edge

    task automatic t_pwm();
        wr(8'h08, 32'hb);
        wr(8'h1c, 32'd100);
        wr(8'h24, 32'd50);
        wr(8'hc0, 32'h3);
        wr(8'h0c, 32'h101);
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        check("pwm_oe", {31'h0, pin_oe[1]}, 32'h1);
        check("pwm_hi", {31'h0, pin_in[1]}, 32'h1);
        wr(8'h08, 32'h1b);
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check("pwm_inv", {31'h0, pin_out[1]}, 32'h0);
    endtask : t_pwm

    task automatic t_capture();
        wr(8'h80, 32'h4);
        wr(8'h84, 32'h7);
        wr(8'h98, 32'h1234);
        wr(8'hc0, 32'h13);
        debug_halt <= 1'b1;
        wr(8'h8c, 32'h3);
        pulse(6'h10);
        debug_halt <= 1'b0;
        wr(8'h98, 32'h5555);
        rd("cap_time", 8'hb8, 32'h1234);
        rd("cap_flag", 8'h90, 32'h4);
    endtask : t_capture

    initial
    begin
        repeat (8) @(posedge mclk);
        rst_n    <= 1'b1;
        gpio_out <= 6'h2a;
        gpio_oe  <= 6'h15;
        repeat (2) @(posedge mclk);
        t_reset();
        t_pair32();
        t_oneshot();
        t_stall();
        t_edge();
        t_pwm();
        t_capture();
        end_of_test();
    end
endmodule : gpt_top_tb
